// File: verilog/gosm_top.v
// APB register block and output drivers for two general-purpose pins
//
// The implementer's own choice: register access over APB.
`include "gosm_map.vh"
module gosm_top (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	// Receive port signals from other clock domains
	input wire [15:0] remote_pins,
	input wire [3:0] rx_lock,
	input wire [3:0] rx_pass,
	input wire [3:0] rx_fv,
	input wire [3:0] rx_lv,
	input wire frame_sync_pulse,
	// Transmit port signals
	input wire [1:0] tx_fv,
	input wire [1:0] tx_lv,
	input wire [1:0] tx_synced,
	input wire [1:0] tx_irq,
	input wire [7:0] tx_rx_map,
	// Pins
	output reg pin2_out,
	output reg pin2_oe,
	output reg pin3_out,
	output reg pin3_oe
);
	reg [7:0] pin2_output_control_r;
	reg [7:0] pin3_output_control_r;
	reg [3:0] rx_enabled_r;
	wire [15:0] remote_pins_s;
	wire [3:0] rx_lock_s;
	wire [3:0] rx_pass_s;
	wire [3:0] rx_fv_s;
	wire [3:0] rx_lv_s;
	wire frame_sync_s;
	wire [1:0] tx_fv_s;
	wire [1:0] tx_lv_s;
	wire [1:0] tx_synced_s;
	wire [1:0] tx_irq_s;
	wire [3:0] pin_status;
	wire pin2_level;
	wire pin3_level;
	wire hit_pin2;
	wire hit_pin3;
	wire hit_ena;
	wire hit_stat;
	wire wr;
	wire wr_pin2;
	wire wr_pin3;
	wire wr_ena;
	wire known;

	// Every selectable signal but the local level comes from another clock domain; one group
	// of synchronisers per source keeps each bit position plain to read
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : sync_remote_g
			gosm_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(remote_pins[g]),
				.sync_out(remote_pins_s[g])
			);
		end

		for (g = 0; g < 4; g = g + 1) begin : sync_lock_g
			gosm_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(rx_lock[g]),
				.sync_out(rx_lock_s[g])
			);
		end

		for (g = 0; g < 4; g = g + 1) begin : sync_pass_g
			gosm_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(rx_pass[g]),
				.sync_out(rx_pass_s[g])
			);
		end

		for (g = 0; g < 4; g = g + 1) begin : sync_fv_g
			gosm_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(rx_fv[g]),
				.sync_out(rx_fv_s[g])
			);
		end

		for (g = 0; g < 4; g = g + 1) begin : sync_lv_g
			gosm_sync3 u_sync (
				.pclk(pclk),
				.presetn(presetn),
				.async_in(rx_lv[g]),
				.sync_out(rx_lv_s[g])
			);
		end
	endgenerate

	// A frame sync pulse shorter than two clocks can be filtered out
	gosm_sync3 u_sync_fs (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(frame_sync_pulse),
		.sync_out(frame_sync_s)
	);

	// Transmit port status, one synchroniser per bit
	gosm_sync3 u_sync_tx_fv0 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_fv[0]),
		.sync_out(tx_fv_s[0])
	);

	gosm_sync3 u_sync_tx_fv1 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_fv[1]),
		.sync_out(tx_fv_s[1])
	);

	gosm_sync3 u_sync_tx_lv0 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_lv[0]),
		.sync_out(tx_lv_s[0])
	);

	gosm_sync3 u_sync_tx_lv1 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_lv[1]),
		.sync_out(tx_lv_s[1])
	);

	gosm_sync3 u_sync_tx_sy0 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_synced[0]),
		.sync_out(tx_synced_s[0])
	);

	gosm_sync3 u_sync_tx_sy1 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_synced[1]),
		.sync_out(tx_synced_s[1])
	);

	gosm_sync3 u_sync_tx_irq0 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_irq[0]),
		.sync_out(tx_irq_s[0])
	);

	gosm_sync3 u_sync_tx_irq1 (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(tx_irq[1]),
		.sync_out(tx_irq_s[1])
	);

	// Zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign hit_pin2 = (paddr == `GOSM_PIN2_ADDR);
	assign hit_pin3 = (paddr == `GOSM_PIN3_ADDR);
	assign hit_ena = (paddr == `GOSM_ENA_ADDR);
	assign hit_stat = (paddr == `GOSM_STAT_ADDR);
	assign known = hit_pin2 || hit_pin3 || hit_ena || hit_stat;
	assign pslverr = psel && penable && !known;
	assign wr = psel && penable && pwrite;
	assign wr_pin2 = wr && hit_pin2;
	assign wr_pin3 = wr && hit_pin3;
	assign wr_ena = wr && hit_ena;
	assign pin_status = {pin3_oe, pin3_out, pin2_oe, pin2_out};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin2_output_control_r <= `GOSM_CTL_RST;
		end else if (wr_pin2) begin
			pin2_output_control_r <= pwdata[7:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin3_output_control_r <= `GOSM_CTL_RST;
		end else if (wr_pin3) begin
			pin3_output_control_r <= pwdata[7:0];
		end
	end

	// The enable set feeds only the status aggregates; it resets to all
	// ports enabled so those aggregates work before software touches it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_enabled_r <= `GOSM_ENA_RST;
		end else if (wr_ena) begin
			rx_enabled_r <= pwdata[3:0];
		end
	end

	always @* begin
		prdata = 32'h00000000;
		case (paddr)
			`GOSM_PIN2_ADDR: prdata[7:0] = pin2_output_control_r;
			`GOSM_PIN3_ADDR: prdata[7:0] = pin3_output_control_r;
			`GOSM_ENA_ADDR: prdata[3:0] = rx_enabled_r;
			`GOSM_STAT_ADDR: prdata[3:0] = pin_status;
			default: prdata = 32'h00000000;
		endcase
	end

	gosm_pin_mux u_mux2 (
		.source_group(pin2_output_control_r[`GOSM_SRC_HI:`GOSM_SRC_LO]),
		.signal_select(pin2_output_control_r[`GOSM_SEL_HI:`GOSM_SEL_LO]),
		.local_level(pin2_output_control_r[`GOSM_VAL_BIT]),
		.remote_pins(remote_pins_s),
		.rx_lock(rx_lock_s),
		.rx_pass(rx_pass_s),
		.rx_fv(rx_fv_s),
		.rx_lv(rx_lv_s),
		.rx_enabled(rx_enabled_r),
		.frame_sync_pulse(frame_sync_s),
		.tx_rx_map(tx_rx_map),
		.tx_fv(tx_fv_s),
		.tx_lv(tx_lv_s),
		.tx_synced(tx_synced_s),
		.tx_irq(tx_irq_s),
		.level(pin2_level)
	);

	// The second pin uses its own local level bit, not the first pin's
	gosm_pin_mux u_mux3 (
		.source_group(pin3_output_control_r[`GOSM_SRC_HI:`GOSM_SRC_LO]),
		.signal_select(pin3_output_control_r[`GOSM_SEL_HI:`GOSM_SEL_LO]),
		.local_level(pin3_output_control_r[`GOSM_VAL_BIT]),
		.remote_pins(remote_pins_s),
		.rx_lock(rx_lock_s),
		.rx_pass(rx_pass_s),
		.rx_fv(rx_fv_s),
		.rx_lv(rx_lv_s),
		.rx_enabled(rx_enabled_r),
		.frame_sync_pulse(frame_sync_s),
		.tx_rx_map(tx_rx_map),
		.tx_fv(tx_fv_s),
		.tx_lv(tx_lv_s),
		.tx_synced(tx_synced_s),
		.tx_irq(tx_irq_s),
		.level(pin3_level)
	);

	// Pin outputs registered so the pad sees no decode glitches; a disabled
	// pin also holds its data low, so nothing stale shows when it is enabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin2_out <= 1'b0;
			pin2_oe <= 1'b0;
		end else begin
			pin2_oe <= pin2_output_control_r[`GOSM_EN_BIT];
			pin2_out <= pin2_output_control_r[`GOSM_EN_BIT] & pin2_level;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin3_out <= 1'b0;
			pin3_oe <= 1'b0;
		end else begin
			pin3_oe <= pin3_output_control_r[`GOSM_EN_BIT];
			pin3_out <= pin3_output_control_r[`GOSM_EN_BIT] & pin3_level;
		end
	end
endmodule

// File: common/gosm_map.vh
// Register map, field layout and code constants for the pin output source mux
`ifndef GOSM_MAP_VH
`define GOSM_MAP_VH
`define GOSM_PIN2_IDX 8'h12
`define GOSM_PIN3_IDX 8'h13
`define GOSM_PIN2_ADDR 12'h048
`define GOSM_PIN3_ADDR 12'h04C
`define GOSM_ENA_ADDR 12'h080
`define GOSM_STAT_ADDR 12'h084
`define GOSM_SEL_HI 7
`define GOSM_SEL_LO 5
`define GOSM_SRC_HI 4
`define GOSM_SRC_LO 2
`define GOSM_VAL_BIT 1
`define GOSM_EN_BIT 0
`define GOSM_CTL_RST 8'h00
`define GOSM_ENA_RST 4'hF
`define GOSM_SRC_DEV 3'h4
`define GOSM_SRC_RSV 3'h5
`define GOSM_SRC_TX0 3'h6
`define GOSM_SRC_TX1 3'h7
`endif

// File: verilog/gosm_sync3.v
// Three-stage synchroniser for one asynchronous level, with agreement filter
module gosm_sync3 (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Level
	input wire async_in,
	output reg sync_out
);
	reg s1_r;
	reg s2_r;
	reg s3_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			// A change counts only once the two later stages agree
			if (s2_r == s3_r) begin
				sync_out <= s3_r;
			end
		end
	end
endmodule

// File: verilog/gosm_pin_mux.v
// One pin's source group and signal select decode
`include "gosm_map.vh"
module gosm_pin_mux (
	// Control register fields
	input wire [2:0] source_group,
	input wire [2:0] signal_select,
	input wire local_level,
	// Receive port signals, four ports
	input wire [15:0] remote_pins,
	input wire [3:0] rx_lock,
	input wire [3:0] rx_pass,
	input wire [3:0] rx_fv,
	input wire [3:0] rx_lv,
	input wire [3:0] rx_enabled,
	input wire frame_sync_pulse,
	// Transmit port signals, two ports
	input wire [7:0] tx_rx_map,
	input wire [1:0] tx_fv,
	input wire [1:0] tx_lv,
	input wire [1:0] tx_synced,
	input wire [1:0] tx_irq,
	// Selected level
	output reg level
);
	reg [3:0] pm;
	reg [3:0] st;
	reg [1:0] rp;
	reg tp;

	always @* begin
		level = 1'b0;
		rp = source_group[1:0];
		tp = source_group[0];
		pm = tp ? tx_rx_map[7:4] : tx_rx_map[3:0];
		st = rx_pass & pm;
		if (!source_group[2]) begin
			case (signal_select)
				3'h0, 3'h1, 3'h2, 3'h3: level = remote_pins[{rp, signal_select[1:0]}];
				3'h4: level = rx_lock[rp];
				3'h5: level = rx_pass[rp];
				3'h6: level = rx_fv[rp];
				3'h7: level = rx_lv[rp];
				default: level = 1'b0;
			endcase
		end else if (source_group == `GOSM_SRC_DEV) begin
			case (signal_select)
				3'h0: level = local_level;
				3'h1: level = |(rx_lock & rx_enabled);
				3'h2: level = (rx_enabled != 4'h0) && ((rx_lock & rx_enabled) == rx_enabled);
				3'h3: level = (rx_enabled != 4'h0) && ((rx_pass & rx_enabled) == rx_enabled);
				3'h4: level = frame_sync_pulse;
				default: level = 1'b0;
			endcase
		end else if (source_group != `GOSM_SRC_RSV) begin
			case (signal_select)
				3'h0: level = (pm != 4'h0) && (st == pm);
				3'h1: level = |st;
				3'h2: level = tx_fv[tp];
				3'h3: level = tx_lv[tp];
				3'h4: level = tx_synced[tp];
				3'h5: level = tx_irq[tp];
				default: level = 1'b0;
			endcase
		end
	end
endmodule

// File: verif/gosm_properties.sv
// Port-level checks for the pin output source mux
`include "gosm_map.vh"
module gosm_properties (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic pin2_out,
	input wire logic pin2_oe,
	input wire logic pin3_out,
	input wire logic pin3_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr2 = psel && penable && pwrite && paddr == `GOSM_PIN2_ADDR;
	wire wr3 = psel && penable && pwrite && paddr == `GOSM_PIN3_ADDR;
	// Register takes one edge, pin one more
	sequence s_lvl2(v); ##2 pin2_oe && pin2_out == v; endsequence
	sequence s_lvl3(v); ##2 pin3_oe && pin3_out == v; endsequence
	a_off_low2: assert property (!pin2_oe |-> !pin2_out)
		else $error("pin2 high undriven");
	a_off_low3: assert property (!pin3_oe |-> !pin3_out)
		else $error("pin3 high undriven");
	a_en_clear2: assert property (wr2 && !pwdata[0] |-> ##2 !pin2_oe)
		else $error("pin2 driven after disable");
	a_local_lvl2: assert property (wr2 && pwdata[7:2] == 6'h04 && pwdata[0] |->
		s_lvl2($past(pwdata[1], 2)))
		else $error("pin2 local level wrong");
	a_local_lvl3: assert property (wr3 && pwdata[7:2] == 6'h04 && pwdata[0] |->
		s_lvl3($past(pwdata[1], 2)))
		else $error("pin3 local level wrong");
	a_rsv_src2: assert property (wr2 && pwdata[4:2] == `GOSM_SRC_RSV && pwdata[0] |->
		s_lvl2(1'b0))
		else $error("pin2 reserved source high");
	a_rsv_sel3: assert property (wr3 && pwdata[4:2] == `GOSM_SRC_DEV && pwdata[7:5] > 3'h4
		&& pwdata[0] |-> s_lvl3(1'b0))
		else $error("pin3 reserved select high");
	a_err_unmapped: assert property (psel && penable && paddr == 12'h100 |-> pready && pslverr)
		else $error("unmapped access not refused");
endmodule
bind gosm_top gosm_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pready, .pslverr, .pin2_out, .pin2_oe, .pin3_out, .pin3_oe);

// File: verif/gosm_pin_sampler.sv
// External logic sampling one output pin
module gosm_pin_sampler (
	// Pin
	input wire logic pclk,
	input wire logic pin_out,
	input wire logic pin_oe,
	// Sampled level
	output logic level
);
	// Undriven pin rests on the board pull-down
	always @(posedge pclk) level <= pin_oe ? pin_out : 1'b0;
endmodule

// File: verif/gosm_top_tb.sv
// Self-checking bench for the pin output source mux
`include "gosm_map.vh"
module gosm_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, pin2_out, pin2_oe, pin3_out, pin3_oe, lvl2, lvl3;
	logic [15:0] remote_pins = 16'h0;
	logic [3:0] rx_lock = 4'h0, rx_pass = 4'h0, rx_fv = 4'h0, rx_lv = 4'h0;
	logic frame_sync_pulse = 1'b0;
	logic [1:0] tx_fv = 2'h0, tx_lv = 2'h0, tx_synced = 2'h0, tx_irq = 2'h0;
	logic [7:0] tx_rx_map = 8'h00;
	int error_cnt = 0, n_tests = 0, cyc = 0;
	always #10 pclk = ~pclk;
	gosm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .remote_pins, .rx_lock, .rx_pass, .rx_fv, .rx_lv,
		.frame_sync_pulse, .tx_fv, .tx_lv, .tx_synced, .tx_irq, .tx_rx_map,
		.pin2_out, .pin2_oe, .pin3_out, .pin3_oe);
	gosm_pin_sampler u_s2 (.pclk, .pin_out(pin2_out), .pin_oe(pin2_oe), .level(lvl2));
	gosm_pin_sampler u_s3 (.pclk, .pin_out(pin3_out), .pin_oe(pin3_oe), .level(lvl3));
	task end_sim;
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			end_sim;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// Async sources need up to five edges, the sampler one more
	task run(input int p, input logic [7:0] c, input logic e);
		apb(1'b1, p == 2 ? `GOSM_PIN2_ADDR : `GOSM_PIN3_ADDR, {24'h0, c});
		repeat (8) @(posedge pclk);
		chk({31'h0, p == 2 ? lvl2 : lvl3}, {31'h0, e});
	endtask
	task t_reg;
		chk({28'h0, lvl2, lvl3, pin2_oe, pin3_oe}, 32'h0);
		apb(1'b0, `GOSM_PIN2_ADDR, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, `GOSM_PIN3_ADDR, 32'hA4);
		apb(1'b0, `GOSM_PIN3_ADDR, 32'h0);
		chk(rd, 32'hA4);
		apb(1'b1, 12'h100, 32'hFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, `GOSM_ENA_ADDR, 32'h0);
		chk(rd, 32'hF);
	endtask
	task t_local;
		run(2, 8'h13, 1'b1);
		apb(1'b0, `GOSM_STAT_ADDR, 32'h0);
		chk(rd, 32'h3);
		run(2, 8'h11, 1'b0);
		run(3, 8'h13, 1'b1);
		run(2, 8'h12, 1'b0);
		chk({31'h0, pin2_oe}, 32'h0);
	endtask
	task t_rx;
		logic [15:0] m;
		// Selected bit alone high, then alone low among all others high
		for (int p = 0; p < 4; p++)
			for (int s = 0; s < 16; s++) begin
				m = s[3] ? 16'hFFFF : 16'h0;
				remote_pins <= m ^ (s[2:0] < 3'h4 ? 16'h1 << (4 * p + s[2:0]) : 16'h0);
				rx_lock <= m[3:0] ^ (s[2:0] == 3'h4 ? 4'h1 << p : 4'h0);
				rx_pass <= m[3:0] ^ (s[2:0] == 3'h5 ? 4'h1 << p : 4'h0);
				rx_fv <= m[3:0] ^ (s[2:0] == 3'h6 ? 4'h1 << p : 4'h0);
				rx_lv <= m[3:0] ^ (s[2:0] == 3'h7 ? 4'h1 << p : 4'h0);
				run(2, {s[2:0], p[2:0], 2'b01}, !s[3]);
			end
	endtask
	task t_dev;
		{rx_lock, rx_pass, frame_sync_pulse} <= {4'h1, 4'hF, 1'b1};
		run(2, 8'h31, 1'b1);
		run(2, 8'h51, 1'b0);
		run(2, 8'h71, 1'b1);
		run(3, 8'h91, 1'b1);
		run(2, 8'hB3, 1'b0);
		run(3, 8'hF3, 1'b0);
		run(2, 8'h17, 1'b0);
		apb(1'b1, `GOSM_ENA_ADDR, 32'h1);
		run(2, 8'h51, 1'b1);
		rx_lock <= 4'h2;
		run(2, 8'h31, 1'b0);
	endtask
	task t_tx;
		{rx_pass, tx_rx_map} <= {4'hF, 8'hFF};
		for (int t = 0; t < 2; t++)
			for (int s = 0; s < 8; s++) begin
				{tx_fv, tx_lv} <= {s == 2 ? 2'h1 << t : 2'h0, s == 3 ? 2'h1 << t : 2'h0};
				{tx_synced, tx_irq} <= {s == 4 ? 2'h1 << t : 2'h0, s == 5 ? 2'h1 << t : 2'h0};
				run(3, {s[2:0], 2'b11, t[0], 2'b01}, s < 6);
			end
		rx_pass <= 4'h1;
		run(3, 8'h19, 1'b0);
		run(3, 8'h39, 1'b1);
		tx_rx_map <= 8'h1E;
		run(3, 8'h1D, 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reg;
		t_local;
		t_rx;
		t_dev;
		t_tx;
		end_sim;
	end
endmodule
